// *** hw/cag_pkg.sv ***
package cag_pkg;
  // Address width and the halfword-select bit (bit 62 in big-endian numbering)
  localparam int AW            = 32;
  localparam int HALF_BIT      = 1;
  // Data address forms
  localparam logic [1:0] EA_LONG_DISP  = 2'h0;
  localparam logic [1:0] EA_SHORT_DISP = 2'h1;
  localparam logic [1:0] EA_SCALED     = 2'h2;
  localparam logic [1:0] EA_INDEXED    = 2'h3;
  // Next-fetch kinds
  localparam logic [2:0] NF_SEQ        = 3'h0;
  localparam logic [2:0] NF_LONG_REL   = 3'h1;
  localparam logic [2:0] NF_COND_REL   = 3'h2;
  localparam logic [2:0] NF_SHORT_REL  = 3'h3;
  localparam logic [2:0] NF_VIA_LINK   = 3'h4;
  localparam logic [2:0] NF_VIA_COUNT  = 3'h5;
  localparam logic [2:0] NF_RETURN     = 3'h6;
  // Return-from-interrupt save register select
  localparam logic [1:0] RET_BASE      = 2'h0;
  localparam logic [1:0] RET_CRITICAL  = 2'h1;
  localparam logic [1:0] RET_DEBUG     = 2'h2;
  localparam logic [1:0] RET_MCHECK    = 2'h3;
  // Instruction lengths in bytes
  localparam logic [31:0] STEP_32      = 32'h0000_0004;
  localparam logic [31:0] STEP_16      = 32'h0000_0002;
  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_LAST_PC   = 8'h08;
  localparam logic [7:0] REG_MISS_PAGE = 8'h0C;
  // Control fields
  localparam int CTRL_CHECK_EN   = 0;
  localparam logic CTRL_RESET    = 1'b1;
  // Status fields
  localparam int ST_COMPACT_INSTR = 0;
  localparam int ST_MISFETCH      = 1;
  localparam int ST_ORDER_MISMATCH = 2;
  localparam int ST_COMPACT_MODE  = 3;
  localparam int ST_MISALIGNED    = 4;
  localparam int ST_MISMATCHED    = 5;
  localparam int ST_BYTE_ORDER    = 6;
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage

// *** hw/cag_addr_fetch.sv ***
// Notes on behaviour
// - Long data form: sign-extended 16-bit displacement plus base, or zero base.
// - Short data form: sign-extended 8-bit displacement plus base, or zero base.
// - Scaled form: zero-extended 4-bit displacement shifted by size, plus base always.
// - Indexed form: index plus base, zero substituted when base index is zero.
// - Long relative branch: 24-bit displacement with zero appended, sign-extended, plus address.
// - Conditional relative branch: 15-bit displacement doubled, sign-extended, plus address.
// - Short relative branch: 8-bit displacement doubled, sign-extended, plus address.
// - Sequential or not-taken: add 4 after 32-bit, 2 after 16-bit instruction.
// - 32-bit linking branch writes own address plus 4 into link register.
// - 16-bit linking branch writes own address plus 2 into link register.
// - Halfword-odd fetch on non-compact page raises misaligned storage exception.
// - Crossing from compact page into non-compact page raises mismatched exception.
// - Compact page marked little-endian raises byte-ordering exception.
// - Exceptions from instructions on compact pages set syndrome compact bit.
// - Misaligned exception or second-half translation miss sets misaligned-fetch syndrome.
// - Mismatched or byte-ordering exception sets order/mismatch syndrome bit.
// - Second-half translation miss saves first-half address; miss-page register names second page.
// - Return from interrupt targets save register bits 0..62 with zero appended.
// - Link or count register branches keep bit 62, clear only bit 63.
// - Fetches from compact pages decode compact; compact mode reported meanwhile.
// - Every generated branch target has its least significant bit forced zero.
module cag_addr_fetch
(
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // Data address request
  input  wire logic          ea_valid,
  input  wire logic [1:0]    ea_mode,
  input  wire logic [4:0]    base_idx,
  input  wire logic [31:0]   base_reg,
  input  wire logic [31:0]   index_reg,
  input  wire logic [15:0]   data_disp,
  input  wire logic [1:0]    op_size,
  output logic [31:0]        ea_addr,
  output logic               ea_done,
  // Next fetch request
  input  wire logic          nf_valid,
  input  wire logic [2:0]    nf_kind,
  input  wire logic          nf_taken,
  input  wire logic          instr_32,
  input  wire logic          link_option,
  input  wire logic [31:0]   cur_addr,
  input  wire logic [23:0]   long_branch_disp,
  input  wire logic [14:0]   cond_branch_disp,
  input  wire logic [7:0]    short_branch_disp,
  input  wire logic [31:0]   link_register,
  input  wire logic [31:0]   count_register,
  input  wire logic [1:0]    ret_sel,
  input  wire logic [31:0]   save_restore_pc_in,
  input  wire logic [31:0]   critical_save_restore_pc,
  input  wire logic [31:0]   debug_save_restore_pc,
  input  wire logic [31:0]   machine_check_save_restore_pc,
  output logic [31:0]        next_fetch_addr,
  output logic               next_fetch_valid,
  output logic [31:0]        link_value,
  output logic               link_we,
  // Fetch check
  input  wire logic          fetch_valid,
  input  wire logic [31:0]   fetch_addr,
  input  wire logic          fetch_crosses_page,
  input  wire logic          page_compact_encoding,
  input  wire logic          page_little_endian,
  input  wire logic          next_page_compact_encoding,
  input  wire logic          second_half_miss,
  output logic               storage_int,
  output logic               tlb_miss_int,
  output logic [31:0]        save_restore_pc,
  output logic [31:0]        miss_page_addr,
  output logic               syndrome_compact_instr,
  output logic               syndrome_misaligned_fetch,
  output logic               syndrome_order_mismatch,
  output logic               compact_mode
);

  typedef struct packed {
    logic        check_en;
    logic        bus_act;
    logic        bus_write;
    logic [7:0]  bus_addr;
    logic [31:0] rdata;
    logic [31:0] ea_addr;
    logic        ea_done;
    logic [31:0] nf_addr;
    logic        nf_done;
    logic [31:0] link_value;
    logic        link_we;
    logic        storage_int;
    logic        tlb_miss_int;
    logic [31:0] srr_pc;
    logic [31:0] miss_page;
    logic        syn_compact;
    logic        syn_misfetch;
    logic        syn_order;
    logic        misaligned;
    logic        mismatched;
    logic        byte_order;
    logic        compact_mode;
  } cag_state_t;

  cag_state_t state;
  cag_state_t next_state;

  logic [31:0] ea_base;
  logic [31:0] ea_sum;
  logic [31:0] nf_sum;
  logic [31:0] nf_step;
  logic [31:0] ret_src;
  logic        exc_misaligned;
  logic        exc_mismatched;
  logic        exc_byte_order;
  logic        exc_any;
  logic        addr_phase;
  logic [7:0]  rd_sel;

  assign addr_phase = hsel && htrans[1] && hready;
  assign rd_sel     = haddr[7:0];

  // Exception detection on each attempted fetch
  assign exc_misaligned = fetch_valid && fetch_addr[cag_pkg::HALF_BIT]
                          && !page_compact_encoding;
  assign exc_mismatched = fetch_valid && fetch_crosses_page && page_compact_encoding
                          && !next_page_compact_encoding;
  assign exc_byte_order = fetch_valid && page_compact_encoding
                          && page_little_endian;
  assign exc_any        = state.check_en
                          && (exc_misaligned || exc_mismatched || exc_byte_order);

  always_comb
  begin
    ea_base = (base_idx == 5'h00) ? 32'h0000_0000 : base_reg;
    case (ea_mode)
      cag_pkg::EA_LONG_DISP:
        ea_sum = ea_base + {{16{data_disp[15]}}, data_disp};
      cag_pkg::EA_SHORT_DISP:
        ea_sum = ea_base + {{24{data_disp[7]}}, data_disp[7:0]};
      cag_pkg::EA_SCALED:
        ea_sum = base_reg + ({28'h000_0000, data_disp[3:0]} << op_size);
      cag_pkg::EA_INDEXED:
        ea_sum = ea_base + index_reg;
      default:
        ea_sum = ea_base;
    endcase
  end

  always_comb
  begin
    case (ret_sel)
      cag_pkg::RET_BASE:     ret_src = save_restore_pc_in;
      cag_pkg::RET_CRITICAL: ret_src = critical_save_restore_pc;
      cag_pkg::RET_DEBUG:    ret_src = debug_save_restore_pc;
      default:               ret_src = machine_check_save_restore_pc;
    endcase
    nf_step = instr_32 ? cag_pkg::STEP_32 : cag_pkg::STEP_16;
    if (!nf_taken)
    begin
      nf_sum = cur_addr + nf_step;
    end
    else
    begin
      case (nf_kind)
        cag_pkg::NF_LONG_REL:
          nf_sum = cur_addr + {{7{long_branch_disp[23]}}, long_branch_disp, 1'b0};
        cag_pkg::NF_COND_REL:
          nf_sum = cur_addr + {{16{cond_branch_disp[14]}}, cond_branch_disp, 1'b0};
        cag_pkg::NF_SHORT_REL:
          nf_sum = cur_addr + {{23{short_branch_disp[7]}}, short_branch_disp, 1'b0};
        cag_pkg::NF_VIA_LINK:
          nf_sum = link_register;
        cag_pkg::NF_VIA_COUNT:
          nf_sum = count_register;
        cag_pkg::NF_RETURN:
          nf_sum = ret_src;
        default:
          nf_sum = cur_addr + nf_step;
      endcase
    end
  end

  always_comb
  begin
    next_state              = state;
    next_state.ea_done      = 1'b0;
    next_state.nf_done      = 1'b0;
    next_state.link_we      = 1'b0;
    next_state.storage_int  = 1'b0;
    next_state.tlb_miss_int = 1'b0;
    // Data address generation
    if (ea_valid)
    begin
      next_state.ea_addr = ea_sum;
      next_state.ea_done = 1'b1;
    end
    // Next fetch address and link value
    if (nf_valid)
    begin
      next_state.nf_addr    = {nf_sum[31:1], 1'b0};
      next_state.nf_done    = 1'b1;
      next_state.link_we    = link_option;
      next_state.link_value = cur_addr + nf_step;
    end
    // Fetch checking
    if (fetch_valid)
    begin
      next_state.compact_mode = page_compact_encoding;
    end
    if (exc_any)
    begin
      next_state.storage_int  = 1'b1;
      next_state.srr_pc       = fetch_addr;
      next_state.syn_compact  = page_compact_encoding;
      next_state.syn_misfetch = exc_misaligned;
      next_state.syn_order    = exc_mismatched || exc_byte_order;
      next_state.misaligned   = exc_misaligned;
      next_state.mismatched   = exc_mismatched;
      next_state.byte_order   = exc_byte_order;
    end
    else if (fetch_valid && second_half_miss)
    begin
      next_state.tlb_miss_int = 1'b1;
      next_state.srr_pc       = fetch_addr;
      next_state.miss_page    = fetch_addr + cag_pkg::STEP_16;
      next_state.syn_compact  = page_compact_encoding;
      next_state.syn_misfetch = 1'b1;
      next_state.syn_order    = 1'b0;
      next_state.misaligned   = 1'b0;
      next_state.mismatched   = 1'b0;
      next_state.byte_order   = 1'b0;
    end
    // Register bus: data phase write
    if (state.bus_act && state.bus_write && state.bus_addr == cag_pkg::REG_CTRL)
    begin
      next_state.check_en = hwdata[cag_pkg::CTRL_CHECK_EN];
    end
    // Register bus: address phase captures read data
    next_state.bus_act = addr_phase;
    if (addr_phase)
    begin
      next_state.bus_write = hwrite;
      next_state.bus_addr  = rd_sel;
      next_state.rdata     = 32'h0000_0000;
      if (!hwrite)
      begin
        case (rd_sel)
          cag_pkg::REG_CTRL:
            next_state.rdata[cag_pkg::CTRL_CHECK_EN] = state.check_en;
          cag_pkg::REG_STATUS:
          begin
            next_state.rdata[cag_pkg::ST_COMPACT_INSTR]  = state.syn_compact;
            next_state.rdata[cag_pkg::ST_MISFETCH]       = state.syn_misfetch;
            next_state.rdata[cag_pkg::ST_ORDER_MISMATCH] = state.syn_order;
            next_state.rdata[cag_pkg::ST_COMPACT_MODE]   = state.compact_mode;
            next_state.rdata[cag_pkg::ST_MISALIGNED]     = state.misaligned;
            next_state.rdata[cag_pkg::ST_MISMATCHED]     = state.mismatched;
            next_state.rdata[cag_pkg::ST_BYTE_ORDER]     = state.byte_order;
          end
          cag_pkg::REG_LAST_PC:
            next_state.rdata = state.srr_pc;
          cag_pkg::REG_MISS_PAGE:
            next_state.rdata = state.miss_page;
          default:
            next_state.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state          <= '0;
      state.check_en <= cag_pkg::CTRL_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs
  assign hreadyout                 = 1'b1;
  assign hresp                     = 1'b0;
  assign hrdata                    = state.rdata;
  assign ea_addr                   = state.ea_addr;
  assign ea_done                   = state.ea_done;
  assign next_fetch_addr           = state.nf_addr;
  assign next_fetch_valid          = state.nf_done;
  assign link_value                = state.link_value;
  assign link_we                   = state.link_we;
  assign storage_int               = state.storage_int;
  assign tlb_miss_int              = state.tlb_miss_int;
  assign save_restore_pc           = state.srr_pc;
  assign miss_page_addr            = state.miss_page;
  assign syndrome_compact_instr    = state.syn_compact;
  assign syndrome_misaligned_fetch = state.syn_misfetch;
  assign syndrome_order_mismatch   = state.syn_order;
  assign compact_mode              = state.compact_mode;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_long_disp_addr: assert property (ea_valid && ea_mode == cag_pkg::EA_LONG_DISP
    |=> ea_done && ea_addr == $past(ea_base) + {{16{$past(data_disp[15])}}, $past(data_disp)})
    else $error("long displacement address wrong");
  a_short_disp_addr: assert property (ea_valid && ea_mode == cag_pkg::EA_SHORT_DISP
    && base_idx == 5'h00 |=> ea_addr == {{24{$past(data_disp[7])}}, $past(data_disp[7:0])})
    else $error("short displacement with zero base wrong");
  a_scaled_base: assert property (ea_valid && ea_mode == cag_pkg::EA_SCALED
    |=> ea_addr == $past(base_reg) + ({28'h000_0000, $past(data_disp[3:0])} << $past(op_size)))
    else $error("scaled displacement address wrong");
  a_indexed_addr: assert property (ea_valid && ea_mode == cag_pkg::EA_INDEXED
    |=> ea_addr == $past(ea_base) + $past(index_reg))
    else $error("indexed address wrong");
  a_seq_step: assert property (nf_valid && !nf_taken
    |=> next_fetch_valid && next_fetch_addr == (($past(cur_addr) + $past(nf_step)) & ~32'h1))
    else $error("sequential fetch step wrong");
  a_target_even: assert property (next_fetch_valid |-> !next_fetch_addr[0])
    else $error("branch target odd");
  a_link_value: assert property (nf_valid && link_option
    |=> link_we && link_value == $past(cur_addr) + ($past(instr_32) ? 32'h4 : 32'h2))
    else $error("link value wrong");
  a_keep_half_bit: assert property (
    nf_valid && nf_taken && nf_kind == cag_pkg::NF_VIA_LINK
    |=> next_fetch_addr[cag_pkg::HALF_BIT] == $past(link_register[cag_pkg::HALF_BIT]))
    else $error("link branch lost halfword bit");
  a_misalign_int: assert property (state.check_en && exc_misaligned
    |=> storage_int && syndrome_misaligned_fetch && save_restore_pc == $past(fetch_addr))
    else $error("misaligned fetch not reported");
  a_order_syndrome: assert property (exc_any && (exc_mismatched || exc_byte_order)
    |=> storage_int && syndrome_order_mismatch && syndrome_compact_instr)
    else $error("order or mismatch syndrome missing");
  a_miss_first_half: assert property (!exc_any && fetch_valid && second_half_miss
    |=> tlb_miss_int && save_restore_pc == $past(fetch_addr)
        && miss_page_addr == $past(fetch_addr) + 32'h2)
    else $error("second half miss report wrong");
  a_long_branch: assert property (
    nf_valid && nf_taken && nf_kind == cag_pkg::NF_LONG_REL |=> next_fetch_addr
      == (($past(cur_addr) + {{7{$past(long_branch_disp[23])}}, $past(long_branch_disp), 1'b0})
      & ~32'h1))
    else $error("long relative branch target wrong");
  a_cond_branch: assert property (
    nf_valid && nf_taken && nf_kind == cag_pkg::NF_COND_REL |=> next_fetch_addr
      == (($past(cur_addr) + {{16{$past(cond_branch_disp[14])}}, $past(cond_branch_disp), 1'b0})
      & ~32'h1))
    else $error("conditional branch target wrong");
  a_short_branch: assert property (
    nf_valid && nf_taken && nf_kind == cag_pkg::NF_SHORT_REL |=> next_fetch_addr
      == (($past(cur_addr) + {{23{$past(short_branch_disp[7])}}, $past(short_branch_disp), 1'b0})
      & ~32'h1))
    else $error("short branch target wrong");
  a_short_link: assert property (nf_valid && link_option && !instr_32
    |=> link_we && link_value == $past(cur_addr) + cag_pkg::STEP_16)
    else $error("short linking value wrong");
  a_return_target: assert property (
    nf_valid && nf_taken && nf_kind == cag_pkg::NF_RETURN && ret_sel == cag_pkg::RET_BASE
    |=> next_fetch_addr == {$past(save_restore_pc_in[31:1]), 1'b0})
    else $error("return target wrong");
  a_mismatch_int: assert property (state.check_en && exc_mismatched
    |=> storage_int && save_restore_pc == $past(fetch_addr))
    else $error("mismatched fetch not reported");
  a_byte_order_int: assert property (state.check_en && exc_byte_order
    |=> storage_int && save_restore_pc == $past(fetch_addr))
    else $error("byte order fetch not reported");
  a_compact_mode: assert property (fetch_valid
    |=> compact_mode == $past(page_compact_encoding))
    else $error("compact mode not reported");
endmodule

// *** verif/cag_mmu_model.sv ***
module cag_mmu_model
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Bench request: {cross, compact, little endian, next compact, second-half miss}
  input  wire logic        req,
  input  wire logic [31:0] req_addr,
  input  wire logic [4:0]  req_attr,
  // Fetch check side
  output logic             fetch_valid,
  output logic [31:0]      fetch_addr,
  output logic             fetch_crosses_page,
  output logic             page_compact_encoding,
  output logic             page_little_endian,
  output logic             next_page_compact_encoding,
  output logic             second_half_miss
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] attr;
  assign {fetch_crosses_page, page_compact_encoding, page_little_endian,
          next_page_compact_encoding, second_half_miss} = attr;
  // Page attributes travel with each fetch; idle lines invert their last value every cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {fetch_valid, fetch_addr, attr} <= '0;
    end
    else if (req)
    begin
      {fetch_valid, fetch_addr, attr} <= {1'b1, req_addr, req_attr};
    end
    else
    begin
      {fetch_valid, fetch_addr, attr} <= {1'b0, ~fetch_addr, ~attr};
    end
  end
endmodule

// *** verif/cag_addr_fetch_tb.sv ***
module cag_addr_fetch_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define chk(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, req;
  logic [31:0] haddr, hwdata, hrdata, rd, base_reg, index_reg, ea_addr, cur_addr;
  logic [1:0]  htrans, ea_mode, op_size, ret_sel;
  logic [2:0]  hsize, nf_kind;
  logic        ea_valid, ea_done, nf_valid, nf_taken, instr_32, link_option;
  logic        next_fetch_valid, link_we, storage_int, tlb_miss_int, compact_mode;
  logic [4:0]  base_idx, req_attr;
  logic [15:0] data_disp;
  logic [23:0] long_branch_disp;
  logic [14:0] cond_branch_disp;
  logic [7:0]  short_branch_disp;
  logic [31:0] link_register, count_register, save_restore_pc_in, critical_save_restore_pc;
  logic [31:0] debug_save_restore_pc, machine_check_save_restore_pc, next_fetch_addr;
  logic [31:0] link_value, fetch_addr, save_restore_pc, miss_page_addr, req_addr;
  logic        fetch_valid, fetch_crosses_page, page_compact_encoding, page_little_endian;
  logic        next_page_compact_encoding, second_half_miss, syndrome_compact_instr;
  logic        syndrome_misaligned_fetch, syndrome_order_mismatch;
  int          fail_count, checks, cycles;
  assign hready = hreadyout;
  cag_addr_fetch i_cag_addr_fetch
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hreadyout,
    .hresp, .hrdata, .ea_valid, .ea_mode, .base_idx, .base_reg, .index_reg, .data_disp,
    .op_size, .ea_addr, .ea_done, .nf_valid, .nf_kind, .nf_taken, .instr_32, .link_option,
    .cur_addr, .long_branch_disp, .cond_branch_disp, .short_branch_disp, .link_register,
    .count_register, .ret_sel, .save_restore_pc_in, .critical_save_restore_pc,
    .debug_save_restore_pc, .machine_check_save_restore_pc, .next_fetch_addr,
    .next_fetch_valid, .link_value, .link_we, .fetch_valid, .fetch_addr, .fetch_crosses_page,
    .page_compact_encoding, .page_little_endian, .next_page_compact_encoding,
    .second_half_miss, .storage_int, .tlb_miss_int, .save_restore_pc, .miss_page_addr,
    .syndrome_compact_instr, .syndrome_misaligned_fetch, .syndrome_order_mismatch,
    .compact_mode
  );
  cag_mmu_model i_cag_mmu_model
  (
    .hclk, .hresetn, .req, .req_addr, .req_attr, .fetch_valid, .fetch_addr,
    .fetch_crosses_page, .page_compact_encoding, .page_little_endian,
    .next_page_compact_encoding, .second_half_miss
  );
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Single word transfer; read data taken at the edge ending the data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, cag_pkg::HTRANS_NONSEQ, a, wr,
                                             cag_pkg::HSIZE_WORD};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    `chk("hresp", 1'b0, hresp)
    `chk("hreadyout", 1'b1, hreadyout)
  endtask
  task automatic test_regs();
    ahb(1'b0, 32'(cag_pkg::REG_CTRL), 32'h0);
    `chk("ctrl reset", 32'h0000_0001, rd)
    ahb(1'b1, 32'(cag_pkg::REG_STATUS), 32'hFFFF_FFFF);
    ahb(1'b0, 32'(cag_pkg::REG_STATUS), 32'h0);
    `chk("status ro", 32'h0000_0000, rd)
    ahb(1'b0, 32'h0000_0010, 32'h0);
    `chk("unmapped", 32'h0000_0000, rd)
    $display("test regs done");
  endtask
  task automatic do_ea(input logic [1:0] m, input logic [4:0] bi, input logic [15:0] d,
                       input logic [1:0] sz, input logic [31:0] e);
    @(posedge hclk);
    {ea_valid, ea_mode, base_idx, data_disp, op_size} <= {1'b1, m, bi, d, sz};
    @(posedge hclk);
    ea_valid <= 1'b0;
    #1;
    `chk("ea_addr", e, ea_addr)
    `chk("ea_done", 1'b1, ea_done)
  endtask
  task automatic test_ea();
    {base_reg, index_reg} <= {32'h0000_1000, 32'h0000_0020};
    do_ea(cag_pkg::EA_LONG_DISP, 5'h03, 16'hFFF0, 2'h0, 32'h0000_0FF0);
    do_ea(cag_pkg::EA_LONG_DISP, 5'h00, 16'hFFF0, 2'h0, 32'hFFFF_FFF0);
    do_ea(cag_pkg::EA_SHORT_DISP, 5'h03, 16'h7F80, 2'h0, 32'h0000_0F80);
    do_ea(cag_pkg::EA_SHORT_DISP, 5'h00, 16'h7F80, 2'h0, 32'hFFFF_FF80);
    do_ea(cag_pkg::EA_SCALED, 5'h00, 16'hFFFF, 2'h2, 32'h0000_103C);
    do_ea(cag_pkg::EA_SCALED, 5'h05, 16'h0013, 2'h1, 32'h0000_1006);
    do_ea(cag_pkg::EA_INDEXED, 5'h03, 16'h0000, 2'h0, 32'h0000_1020);
    do_ea(cag_pkg::EA_INDEXED, 5'h00, 16'h0000, 2'h0, 32'h0000_0020);
    $display("test ea done");
  endtask
  task automatic do_nf(input logic [2:0] k, input logic t, input logic i, input logic l,
                       input logic [1:0] r, input logic [31:0] en, input logic [31:0] el);
    @(posedge hclk);
    {nf_valid, nf_kind, nf_taken, instr_32, link_option, ret_sel} <= {1'b1, k, t, i, l, r};
    @(posedge hclk);
    nf_valid <= 1'b0;
    #1;
    `chk("next_fetch_addr", en, next_fetch_addr)
    `chk("next_fetch_valid", 1'b1, next_fetch_valid)
    `chk("link_we", l, link_we)
    if (l) `chk("link_value", el, link_value)
  endtask
  task automatic test_nf();
    {cur_addr, long_branch_disp, cond_branch_disp} <= {32'h0000_2000, 24'hFFFFFE, 15'h0010};
    {short_branch_disp, link_register, count_register} <= {8'h80, 32'h3003, 32'h4007};
    {save_restore_pc_in, critical_save_restore_pc} <= {32'h0000_5003, 32'h0000_6007};
    {debug_save_restore_pc, machine_check_save_restore_pc} <= {32'h700B, 32'h800F};
    do_nf(cag_pkg::NF_LONG_REL, 1, 1, 0, 0, 32'h0000_1FFC, 0);
    do_nf(cag_pkg::NF_COND_REL, 1, 1, 1, 0, 32'h0000_2020, 32'h2004);
    do_nf(cag_pkg::NF_SHORT_REL, 1, 0, 1, 0, 32'h0000_1F00, 32'h2002);
    do_nf(cag_pkg::NF_LONG_REL, 0, 1, 1, 0, 32'h0000_2004, 32'h2004);
    do_nf(cag_pkg::NF_SEQ, 1, 0, 0, 0, 32'h0000_2002, 0);
    do_nf(cag_pkg::NF_VIA_LINK, 1, 0, 1, 0, 32'h0000_3002, 32'h2002);
    do_nf(cag_pkg::NF_VIA_COUNT, 1, 1, 0, 0, 32'h0000_4006, 0);
    for (int i = 0; i < 4; i++)
      do_nf(cag_pkg::NF_RETURN, 1, 1, 0, i[1:0], 32'(32'h5002 + 32'h1004 * i), 0);
    $display("test nf done");
  endtask
  task automatic do_f(input logic [31:0] a, input logic [4:0] at, input logic si,
                      input logic mi, input logic [2:0] syn, input logic md);
    @(posedge hclk);
    {req, req_addr, req_attr} <= {1'b1, a, at};
    @(posedge hclk);
    req <= 1'b0;
    @(posedge hclk);
    #1;
    `chk("storage_int", si, storage_int)
    `chk("tlb_miss_int", mi, tlb_miss_int)
    `chk("compact_mode", md, compact_mode)
    if (si | mi)
    begin
      `chk("save_restore_pc", a, save_restore_pc)
      `chk("syndrome", syn, {syndrome_order_mismatch, syndrome_misaligned_fetch,
                             syndrome_compact_instr})
    end
  endtask
  task automatic test_fetch();
    do_f(32'h0000_1002, 5'b00000, 1, 0, 3'b010, 0);
    do_f(32'h0000_1000, 5'b00000, 0, 0, 3'b000, 0);
    do_f(32'h0000_1002, 5'b01000, 0, 0, 3'b000, 1);
    do_f(32'h0000_0FFE, 5'b11000, 1, 0, 3'b101, 1);
    do_f(32'h0000_0FFE, 5'b11010, 0, 0, 3'b000, 1);
    do_f(32'h0000_2000, 5'b01100, 1, 0, 3'b101, 1);
    ahb(1'b0, 32'(cag_pkg::REG_STATUS), 32'h0);
    `chk("status", 32'h0000_004D, rd)
    do_f(32'h0000_1FFE, 5'b11011, 0, 1, 3'b011, 1);
    `chk("miss_page_addr", 32'h0000_2000, miss_page_addr)
    ahb(1'b0, 32'(cag_pkg::REG_MISS_PAGE), 32'h0);
    `chk("miss page reg", 32'h0000_2000, rd)
    ahb(1'b1, 32'(cag_pkg::REG_CTRL), 32'h0);
    ahb(1'b0, 32'(cag_pkg::REG_CTRL), 32'h0);
    `chk("ctrl", 32'h0000_0000, rd)
    do_f(32'h0000_1002, 5'b00000, 0, 0, 3'b000, 0);
    ahb(1'b1, 32'(cag_pkg::REG_CTRL), 32'h1);
    do_f(32'h0000_3002, 5'b00100, 1, 0, 3'b010, 0);
    $display("test fetch done");
  endtask
  initial
  begin
    {hresetn, hsel, hwrite, ea_valid, nf_valid, nf_taken, instr_32, link_option, req} = '0;
    {haddr, hwdata, htrans, hsize, ea_mode, op_size, ret_sel, nf_kind, base_idx} = '0;
    {base_reg, index_reg, cur_addr, data_disp, long_branch_disp, cond_branch_disp} = '0;
    {short_branch_disp, link_register, count_register, save_restore_pc_in} = '0;
    {critical_save_restore_pc, debug_save_restore_pc, machine_check_save_restore_pc} = '0;
    {req_addr, req_attr, fail_count, checks, cycles} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    test_regs();
    test_ea();
    test_nf();
    test_fetch();
    results();
  end
endmodule
